// file: rtl/i2c_switch_master.sv
// upstream master end: APB slave with a command register, drives one I2C transfer
// assumes the device answers on the shared open-drain link
//
// Our own choices: register access over APB and the placing of the registers.
module i2c_switch_master (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// link
	i2c_switch_if.master bus
);
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_BYTE = 3'b010,
		M_STOP = 3'b011,
		M_DONE = 3'b100
	} mst_state_t;

	logic [7:0] sda_sync_r, sda_s_r;
	mst_state_t state_r, state_nxt;
	logic [7:0] wdata_r, wdata_nxt, addr_r, addr_nxt, rdata_r, rdata_nxt, sh_r, sh_nxt;
	logic rd_r, rd_nxt, nack_r, nack_nxt, scl_r, scl_nxt, sda_r, sda_nxt, phase_r, phase_nxt;
	logic [8:0] tick_r, tick_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [31:0] prdata_nxt, prdata_r;
	logic acc, wr, tick_done, data_byte_r, data_byte_nxt;

	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign tick_done = tick_r == 9'(i2c_switch_pkg::SCL_HALF_CYC - 1);

	// ************
	// transfer engine
	// ************
	always_comb begin
		state_nxt = state_r;
		wdata_nxt = wdata_r;
		addr_nxt = addr_r;
		rdata_nxt = rdata_r;
		sh_nxt = sh_r;
		rd_nxt = rd_r;
		nack_nxt = nack_r;
		scl_nxt = scl_r;
		sda_nxt = sda_r;
		phase_nxt = phase_r;
		bit_nxt = bit_r;
		data_byte_nxt = data_byte_r;
		tick_nxt = (state_r == M_IDLE || tick_done) ? 9'h000 : tick_r + 9'h001;
		prdata_nxt = 32'h0000_0000;
		if (wr && paddr_i == i2c_switch_pkg::REG_WDATA) begin
			wdata_nxt = pwdata_i[7:0];
		end
		// address frozen while a transfer runs, like the ignored go bit
		if (wr && paddr_i == i2c_switch_pkg::REG_CMD && state_r == M_IDLE) begin
			addr_nxt = pwdata_i[15:8];
		end
		if (psel_i && !penable_i && !pwrite_i) begin
			case (paddr_i)
				i2c_switch_pkg::REG_WDATA: prdata_nxt = {24'h000000, wdata_r};
				i2c_switch_pkg::REG_STATUS: prdata_nxt = {16'h0000, rdata_r, 6'h00, nack_r,
					state_r != M_IDLE};
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
		case (state_r)
			M_IDLE: begin
				if (wr && paddr_i == i2c_switch_pkg::REG_CMD
						&& pwdata_i[i2c_switch_pkg::CMD_GO_BIT]) begin
					rd_nxt = pwdata_i[i2c_switch_pkg::CMD_READ_BIT];
					nack_nxt = 1'b0;
					state_nxt = M_START;
					sda_nxt = 1'b0;
				end
			end
			M_START: begin
				if (tick_done) begin
					scl_nxt = 1'b0;
					sh_nxt = {addr_r[7:1], rd_r}; // [RQ4] [RQ5]
					bit_nxt = 4'h0;
					phase_nxt = 1'b0;
					data_byte_nxt = 1'b0;
					state_nxt = M_BYTE;
				end
			end
			M_BYTE: begin
				if (tick_done) begin
					if (!scl_r) begin
						if (!phase_r) begin
							if (bit_r == 4'h8) begin
								// ack slot: master always releases sda, so a read byte gets the nack [RQ21]
								// single byte only: released for the slave ack or as read nack
								sda_nxt = 1'b1;
							end else begin
								sda_nxt = (data_byte_r & rd_r) | sh_r[7];
							end
							phase_nxt = 1'b1;
						end else begin
							scl_nxt = 1'b1;
							phase_nxt = 1'b0;
						end
					end else begin
						scl_nxt = 1'b0;
						if (bit_r == 4'h8) begin
							if (!data_byte_r && sda_s_r[0]) begin
								nack_nxt = 1'b1;
								state_nxt = M_STOP;
							end else if (data_byte_r) begin
								state_nxt = M_STOP;
							end else begin
								data_byte_nxt = 1'b1;
								sh_nxt = wdata_r;
								bit_nxt = 4'h0;
							end
							sda_nxt = 1'b0;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							rdata_nxt = {rdata_r[6:0], sda_s_r[0]};
							bit_nxt = bit_r + 4'h1;
						end
					end
				end
			end
			M_STOP: begin
				if (tick_done) begin
					if (!scl_r) begin
						scl_nxt = 1'b1;
					end else begin
						sda_nxt = 1'b1;
						state_nxt = M_DONE;
					end
				end
			end
			M_DONE: begin
				if (tick_done) begin
					state_nxt = M_IDLE;
				end
			end
			default: begin
				state_nxt = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sda_sync_r <= 8'hFF;
			sda_s_r <= 8'hFF;
			state_r <= M_IDLE;
			wdata_r <= 8'h00;
			addr_r <= 8'h00;
			rdata_r <= 8'h00;
			sh_r <= 8'h00;
			rd_r <= 1'b0;
			nack_r <= 1'b0;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			phase_r <= 1'b0;
			bit_r <= 4'h0;
			data_byte_r <= 1'b0;
			tick_r <= 9'h000;
			prdata_r <= 32'h0000_0000;
		end else if (clk_en_i) begin
			sda_sync_r <= {7'h7F, bus.sda};
			sda_s_r <= sda_sync_r;
			state_r <= state_nxt;
			wdata_r <= wdata_nxt;
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
			sh_r <= sh_nxt;
			rd_r <= rd_nxt;
			nack_r <= nack_nxt;
			scl_r <= scl_nxt;
			sda_r <= sda_nxt;
			phase_r <= phase_nxt;
			bit_r <= bit_nxt;
			data_byte_r <= data_byte_nxt;
			tick_r <= tick_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign bus.scl_o_m = 1'b0;
	assign bus.scl_oe_n_m = scl_r;
	assign bus.sda_o_m = 1'b0;
	assign bus.sda_oe_n_m = sda_r;
endmodule : i2c_switch_master

// file: rtl/i2c_switch_pkg.sv
// constants shared by the switch device end and the upstream master end
// assumes both ends sample the link on core_clk_i at 100 MHz
package i2c_switch_pkg;
	// fixed upper part of the seven-bit slave address (arbitrary value)
	localparam logic [4:0] ADDR_FIXED = 5'h1C;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CHAN_LSB = 0;
	localparam int IRQ_LSB = 4;
	localparam int NUM_CHAN = 4;
	// master register map, one aligned word each
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_NACK_BIT = 1;
	localparam int ST_RDATA_LSB = 8;
	// link timing: one scl bit takes three of these phases, so this keeps scl near 267 kHz
	localparam int CLK_MHZ = 100;
	localparam int SCL_HALF_NS = 1250;
	localparam int SCL_HALF_CYC = SCL_HALF_NS * CLK_MHZ / 1000;
	localparam logic [1:0] ADDR_SEL_RESET = 2'h0;
endpackage : i2c_switch_pkg

// file: rtl/i2c_switch_if.sv
// link between the upstream master and the switch
// open-drain: a line is low when any enable (active low) is low
interface i2c_switch_if;
	logic scl_o_m;
	logic scl_oe_n_m;
	logic sda_o_m;
	logic sda_oe_n_m;
	logic sda_o_d;
	logic sda_oe_n_d;
	logic scl;
	logic sda;
	assign scl = scl_oe_n_m | scl_o_m;
	assign sda = (sda_oe_n_m | sda_o_m) & (sda_oe_n_d | sda_o_d);
	modport master (output scl_o_m, output scl_oe_n_m, output sda_o_m, output sda_oe_n_m,
		input scl, input sda);
	modport device (output sda_o_d, output sda_oe_n_d, input scl, input sda);
endinterface : i2c_switch_if

// file: rtl/i2c_switch_dev.sv
// switch device end: I2C slave with one control byte, channel enables, irq logic
// assumes scl and sda come from another domain and are synchronised here
//
// How it works
// RQ1 - irq output is AND of four inputs
// RQ2 - irq output open-drain, driven only low
// RQ3 - reset clears state machine and channels
// RQ4 - master sends address and direction after start
// RQ5 - address last bit: 1 read, 0 write
// RQ6 - two select pins form low address bits
// RQ7 - byte after acked write address stored
// RQ8 - several bytes: last one kept
// RQ9 - control register writable and readable
// RQ10 - bits 0..3 enable channels 0..3
// RQ11 - new selection applied at stop only
// RQ12 - reset value of register is zero
// RQ13 - irq detection independent of selection
// RQ14 - bits 4..7 show irq of channels
// RQ15 - irq levels captured when read happens
// RQ16 - status bit reads 1 when input low
// RQ17 - master reads, selects, clears source
// RQ18 - master polls every device on channel
// RQ19 - irq inputs usable as general inputs
// RQ20 - slave acks each received byte
// RQ21 - master nacks last read byte, stops
// RQ22 - writes to bits 4..7 ignored
// RQ23 - no ack for foreign address
module i2c_switch_dev (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// link
	i2c_switch_if.device bus,
	// pins
	input wire logic addr_select_0_i,
	input wire logic addr_select_1_i,
	input wire logic [3:0] irq_in_n_i,
	output logic irq_out_o,
	output logic irq_out_oe_n_o,
	output logic [3:0] chan_en_o
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_WDATA = 3'b010,
		S_RDATA = 3'b011,
		S_SKIP = 3'b100
	} dev_state_t;

	// ************
	// synchronisers
	// ************
	logic [7:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
	logic scl_prev_r, sda_prev_r, scl_prev_nxt, sda_prev_nxt;
	always_comb begin
		sync1_nxt = {irq_in_n_i, addr_select_1_i, addr_select_0_i, bus.scl, bus.sda};
		sync2_nxt = sync1_r;
		scl_prev_nxt = sync2_r[1];
		sda_prev_nxt = sync2_r[0];
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_r <= 8'hFF;
			sync2_r <= 8'hFF;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else if (clk_en_i) begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			scl_prev_r <= scl_prev_nxt;
			sda_prev_r <= sda_prev_nxt;
		end
	end
	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	logic [3:0] irq_n_s;
	logic [6:0] own_addr;
	assign scl_s = sync2_r[1];
	assign sda_s = sync2_r[0];
	assign irq_n_s = sync2_r[7:4];
	assign scl_rise = scl_s & ~scl_prev_r;
	assign scl_fall = ~scl_s & scl_prev_r;
	assign start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
	assign stop_det = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
	assign own_addr = {i2c_switch_pkg::ADDR_FIXED, sync2_r[3:2]}; // [RQ6]

	// irq output follows inputs whether or not a channel is selected
	assign irq_out_o = 1'b0;
	assign irq_out_oe_n_o = &irq_n_s; // [RQ1] [RQ2] [RQ13]

	// ************
	// byte engine
	// ************
	dev_state_t state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic ack_phase_r, ack_phase_nxt;
	logic drive_low_r, drive_low_nxt;
	logic [3:0] pend_r, pend_nxt;
	logic [3:0] chan_r, chan_nxt;
	logic pend_valid_r, pend_valid_nxt;
	logic read_nack_r, read_nack_nxt;

	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		ack_phase_nxt = ack_phase_r;
		drive_low_nxt = drive_low_r;
		pend_nxt = pend_r;
		chan_nxt = chan_r;
		pend_valid_nxt = pend_valid_r;
		read_nack_nxt = read_nack_r;
		if (stop_det) begin
			state_nxt = S_IDLE;
			drive_low_nxt = 1'b0;
			if (pend_valid_r) begin
				chan_nxt = pend_r; // [RQ11]
			end
			pend_valid_nxt = 1'b0;
		end else if (start_det) begin
			state_nxt = S_ADDR; // [RQ4]
			bit_cnt_nxt = 4'h0;
			ack_phase_nxt = 1'b0;
			drive_low_nxt = 1'b0;
		end else begin
			case (state_r)
				S_IDLE, S_SKIP: begin
					drive_low_nxt = 1'b0;
				end
				S_ADDR, S_WDATA: begin
					if (scl_rise && !ack_phase_r) begin
						shift_nxt = {shift_r[6:0], sda_s};
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall && !ack_phase_r && bit_cnt_r == 4'h8) begin
						ack_phase_nxt = 1'b1;
						if (state_r == S_WDATA) begin
							drive_low_nxt = 1'b1; // [RQ20]
							pend_nxt = shift_r[3:0]; // [RQ7] [RQ8] [RQ22]
							pend_valid_nxt = 1'b1;
						end else if (shift_r[7:1] == own_addr) begin
							drive_low_nxt = 1'b1; // [RQ20]
						end else begin
							state_nxt = S_SKIP; // [RQ23]
						end
					end else if (scl_fall && ack_phase_r) begin
						ack_phase_nxt = 1'b0;
						bit_cnt_nxt = 4'h0;
						drive_low_nxt = 1'b0;
						if (state_r == S_ADDR && shift_r[0]) begin
							state_nxt = S_RDATA; // [RQ5]
							// irq levels sampled now, at the read [RQ15] [RQ14] [RQ16] [RQ19]
							shift_nxt = {~irq_n_s, chan_r}; // [RQ9] [RQ10]
							// msb first: bit 7 is the flag of channel 3, set when its input is low
							drive_low_nxt = irq_n_s[3];
							bit_cnt_nxt = 4'h1;
						end else begin
							state_nxt = S_WDATA;
						end
					end
				end
				S_RDATA: begin
					if (scl_fall && !ack_phase_r) begin
						if (bit_cnt_r == 4'h8) begin
							ack_phase_nxt = 1'b1;
							drive_low_nxt = 1'b0;
						end else begin
							drive_low_nxt = ~shift_r[3'h7 - bit_cnt_r[2:0]];
							bit_cnt_nxt = bit_cnt_r + 4'h1;
						end
					end else if (scl_rise && ack_phase_r) begin
						read_nack_nxt = sda_s;
					end else if (scl_fall && ack_phase_r) begin
						ack_phase_nxt = 1'b0;
						if (read_nack_r) begin
							state_nxt = S_SKIP; // [RQ21]
						end else begin
							shift_nxt = {~irq_n_s, chan_r};
							drive_low_nxt = irq_n_s[3];
							bit_cnt_nxt = 4'h1;
						end
					end
				end
				default: begin
					state_nxt = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= S_IDLE; // [RQ3]
			shift_r <= i2c_switch_pkg::CTRL_RESET;
			bit_cnt_r <= 4'h0;
			ack_phase_r <= 1'b0;
			drive_low_r <= 1'b0;
			pend_r <= 4'h0;
			chan_r <= 4'h0; // [RQ3] [RQ12]
			pend_valid_r <= 1'b0;
			read_nack_r <= 1'b0;
		end else if (clk_en_i) begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			ack_phase_r <= ack_phase_nxt;
			drive_low_r <= drive_low_nxt;
			pend_r <= pend_nxt;
			chan_r <= chan_nxt;
			pend_valid_r <= pend_valid_nxt;
			read_nack_r <= read_nack_nxt;
		end
	end

	assign bus.sda_o_d = 1'b0;
	assign bus.sda_oe_n_d = ~drive_low_r;
	assign chan_en_o = chan_r;
endmodule : i2c_switch_dev

// file: tb/i2c_switch_sva.sv
// checker for the link between the two ends and for the device pins
// assumes the bench instantiates it beside the interface, all on core_clk_i
module i2c_switch_sva (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_oe_n_d,
	// device pins
	input wire logic addr_select_0_i,
	input wire logic addr_select_1_i,
	input wire logic [3:0] irq_in_n_i,
	input wire logic irq_out_o,
	input wire logic irq_out_oe_n_o,
	input wire logic [3:0] chan_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// frame tracking
	// ****************
	logic scl_r, sda_r, rise, match;
	logic [4:0] cnt_r;
	logic [7:0] sh_r;
	assign rise = scl & !scl_r;
	assign match = sh_r[7:1] == {i2c_switch_pkg::ADDR_FIXED, addr_select_1_i, addr_select_0_i};
	// count saturates so idle rises never look like an acknowledge slot
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_r <= 1'h1;
			sda_r <= 1'h1;
			cnt_r <= 5'h1F;
			sh_r <= 8'h00;
		end else begin
			scl_r <= scl;
			sda_r <= sda;
			if (scl && scl_r && sda_r && !sda) begin
				cnt_r <= 5'h00;
			end else if (rise && cnt_r != 5'h1F) begin
				cnt_r <= cnt_r + 5'h01;
			end
			if (rise && cnt_r < 5'h08) begin
				sh_r <= {sh_r[6:0], sda};
			end
		end
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	irq_od_a: assert property (!irq_out_o)
		else $error("irq output driven high");
	irq_and_a: assert property ($stable(irq_in_n_i) [*6] |->
		irq_out_oe_n_o == (&irq_in_n_i)) else $error("irq output not the and of inputs");
	chan_stop_a: assert property ($changed(chan_en_o) |-> scl && sda)
		else $error("channels changed outside idle bus");
	dev_sda_a: assert property ($changed(sda_oe_n_d) |-> !scl)
		else $error("device moved sda while scl high");
	addr_ack_a: assert property (rise && cnt_r == 5'h08 && match |-> !sda)
		else $error("own address not acknowledged");
	addr_nack_a: assert property (rise && cnt_r == 5'h08 && !match |-> sda)
		else $error("foreign address acknowledged");
	data_ack_a: assert property (rise && cnt_r == 5'h11 && match && !sh_r[0] |-> !sda)
		else $error("written byte not acknowledged");
	rd_free_a: assert property (rise && cnt_r == 5'h11 && match && sh_r[0] |-> sda)
		else $error("device held sda in read acknowledge slot");
	rst_clear_a: assert property (disable iff (1'h0) !reset_n_i |->
		chan_en_o == 4'h0 && sda_oe_n_d) else $error("reset left state behind");
	cover property (rise && cnt_r == 5'h08 && match && sh_r[0]);
	cover property (rise && cnt_r == 5'h08 && !match);
	cover property ($changed(chan_en_o));
endmodule : i2c_switch_sva

// file: tb/tb.sv
// self-checking bench: apb drives the master end, which talks to the device end
// assumes zero-wait apb and one data byte per transfer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, a0, a1, irq_out, irq_oe_n;
	logic [7:0] paddr, rb;
	logic [31:0] pwdata, prdata, q, v;
	logic [3:0] irq_n, chan_en;
	int seed = 38668;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	i2c_switch_if bus ();
	i2c_switch_master i_i2c_switch_master (.core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'h1),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus(bus));
	i2c_switch_dev i_i2c_switch_dev (.core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'h1),
		.bus(bus), .addr_select_0_i(a0), .addr_select_1_i(a1), .irq_in_n_i(irq_n),
		.irq_out_o(irq_out), .irq_out_oe_n_o(irq_oe_n), .chan_en_o(chan_en));
	i2c_switch_sva i_i2c_switch_sva (.core_clk_i(clk), .reset_n_i(rst_n), .scl(bus.scl),
		.sda(bus.sda), .sda_oe_n_d(bus.sda_oe_n_d), .addr_select_0_i(a0), .addr_select_1_i(a1),
		.irq_in_n_i(irq_n), .irq_out_o(irq_out), .irq_out_oe_n_o(irq_oe_n), .chan_en_o(chan_en));
	// ****************
	// clock, timeout, helpers
	// ****************
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 98000) begin
			miscompares++;
			wrap_up();
		end
	end
	task wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		q = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wb);
		apb(1'h1, i2c_switch_pkg::REG_WDATA, {24'h0, wb});
		apb(1'h1, i2c_switch_pkg::REG_CMD, {16'h0, adr, 7'h00, rd, 1'h1});
		do apb(1'h0, i2c_switch_pkg::REG_STATUS, 32'h0); while (q[0] !== 1'h0);
		// the device applies a new selection a few cycles after the stop
		repeat (8) @(posedge clk);
		rb = q[15:8];
	endtask : xfer
	function logic [6:0] own();
		return {i2c_switch_pkg::ADDR_FIXED, a1, a0};
	endfunction : own
	function logic [7:0] exp_rd(input logic [3:0] n, input logic [3:0] s);
		return {~n, s};
	endfunction : exp_rd
	// ****************
	// main sequence
	// ****************
	initial begin
		rst_n <= 1'h0;
		{psel, penable, pwrite, a0, a1} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		irq_n = 4'hF;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		chk({4'h0, chan_en}, 8'h00);
		xfer(1'h1, own(), 8'h00);
		chk(rb, exp_rd(4'hF, 4'h0));
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			irq_n <= i[3:0];
			repeat (6) @(posedge clk);
			chk({7'h0, irq_oe_n}, {7'h0, &i[3:0]});
		end
		$display("test irq done");
		for (int k = 0; k < 2; k++) begin
			v = $random(seed);
			// first pass is a corner: all channels on, upper bits written too
			if (k == 0) v[15:8] = 8'h5F;
			{a1, a0} <= v[1:0];
			irq_n <= v[7:4];
			repeat (4) @(posedge clk);
			xfer(1'h0, own(), v[15:8]);
			chk({4'h0, chan_en}, {4'h0, v[11:8]});
			xfer(1'h1, own(), 8'h00);
			chk(rb, exp_rd(v[7:4], v[11:8]));
		end
		$display("test select done");
		xfer(1'h0, own() ^ 7'h01, ~v[15:8]);
		chk({7'h0, q[1]}, 8'h01);
		chk({4'h0, chan_en}, {4'h0, v[11:8]});
		$display("test foreign done");
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		chk({4'h0, chan_en}, 8'h00);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		xfer(1'h1, own(), 8'h00);
		chk(rb, exp_rd(irq_n, 4'h0));
		$display("test rerun done");
		// service: select exactly the channels flagged in the status just read
		xfer(1'h0, own(), {4'h0, rb[7:4]});
		chk({4'h0, chan_en}, {4'h0, ~irq_n});
		$display("test service done");
		wrap_up();
	end
endmodule : tb
